// ===== common/wwdt_regs.svh
/*
  windowed watchdog timer: register offsets, field positions, reset values
  and timing counts. assumes a 250 mhz system clock and a plain
  address/strobe register port.
*/
`ifndef WWDT_REGS_SVH
`define WWDT_REGS_SVH

// ---------------------------------------------------------------
// register offsets (word addresses on the plain port)
// ---------------------------------------------------------------
`define WWDT_ADDR_W            4
`define WWDT_OFF_RESET_CTRL    4'h0
`define WWDT_OFF_CONFIG_ONE    4'h1

// ---------------------------------------------------------------
// reset_control_reg fields
// ---------------------------------------------------------------
`define WWDT_RC_IDLE_BIT       2
`define WWDT_RC_SLEEP_BIT      3
`define WWDT_RC_TIMEOUT_BIT    4
`define WWDT_RC_SWEN_BIT       5

// ---------------------------------------------------------------
// config_word_one fields
// ---------------------------------------------------------------
`define WWDT_CW_PS_LSB         0
`define WWDT_CW_PS_MSB         3
`define WWDT_CW_PRESEL_BIT     4
`define WWDT_CW_WINDOW_DISABLE_CFG_BIT     6
`define WWDT_CW_HWEN_BIT       7
// unprogrammed word: every bit set
`define WWDT_CW_RESET          8'hff

// ---------------------------------------------------------------
// timing
// ---------------------------------------------------------------
`define WWDT_SYS_CLK_HZ        250000000
`define WWDT_LOW_POWER_RC_CLOCK_HZ           31000
`define WWDT_LOW_POWER_RC_CLOCK_DIV_CYC      (`WWDT_SYS_CLK_HZ / `WWDT_LOW_POWER_RC_CLOCK_HZ)
`define WWDT_PRE_SHORT_BITS    5
`define WWDT_PRE_LONG_BITS     7
`define WWDT_POST_BITS         15

`endif

// ===== common/wwdt_pkg.sv
/*
  windowed watchdog timer: shared types. assumes wwdt_regs.svh for the
  numeric constants.
*/
`default_nettype none

package wwdt_pkg;

  // core events, each a one-cycle pulse on the system clock
  typedef struct packed {
    logic dev_reset;        // any device reset
    logic clk_switch_done;  // hardware or software clock switch completed
    logic power_save_instruction_enter;     // power_save_instruction executed
    logic power_save_instruction_idle;      // with power_save_instruction_enter: 1 = idle, 0 = sleep
    logic power_save_instruction_exit;      // leaving sleep or idle
    logic clear_instr;      // watchdog_clear_instruction executed
  } wwdt_core_evt_t;

  // register port request
  typedef struct packed {
    logic       wr;
    logic       rd;
    logic [3:0] addr;
    logic [7:0] wdata;
  } wwdt_bus_req_t;

  // power state
  typedef enum logic [1:0] {
    WWDT_RUN,
    WWDT_SLEEP,
    WWDT_IDLE
  } wwdt_pstate_t;

endpackage

`default_nettype wire

// ===== logic/wwdt_prescaler.sv
/*
  prescaler: counts low-power clock ticks, wraps at 32 or 128.
  assumes tick_in is a one-cycle enable on the system clock.
*/
`timescale 1ns/1ps
`default_nettype none

module wwdt_prescaler
#(
  parameter int LONG_BITS = 7
)
(
  input  wire logic                 sys_clk_in,
  input  wire logic                 rstn_in,
  input  wire logic                 clear_in,     // synchronous clear
  input  wire logic                 tick_in,      // low_power_rc_clock enable
  input  wire logic                 long_sel_in,  // 1 = divide by 128
  output logic [LONG_BITS-1:0]      count_out,    // current count
  output logic                      wrap_out      // one-cycle wrap pulse
);

  logic [LONG_BITS-1:0] cnt_r;   // prescale count
  logic                 last_w;  // last count of the chosen length

  // ---------------------------------------------------------------
  // wrap detect
  // ---------------------------------------------------------------
  // short mode looks only at the low five bits
  assign last_w = long_sel_in ? (&cnt_r) : (&cnt_r[4:0]);
  assign wrap_out = tick_in & last_w & ~clear_in;
  assign count_out = cnt_r;

  // ---------------------------------------------------------------
  // counter
  // ---------------------------------------------------------------
  always_ff @(posedge sys_clk_in or negedge rstn_in)
  begin
    if (!rstn_in)
      cnt_r <= '0;
    else if (clear_in)
      cnt_r <= '0;
    else if (tick_in && wrap_out)
      cnt_r <= '0;
    else if (tick_in)
      cnt_r <= cnt_r + 1'b1;
  end

endmodule

`default_nettype wire

// ===== logic/wwdt_postscaler.sv
/*
  postscaler: counts prescaler wraps, expires after 2**select of them.
  assumes step_in is a one-cycle pulse on the system clock.
*/
`timescale 1ns/1ps
`default_nettype none

module wwdt_postscaler
#(
  parameter int BITS = 15
)
(
  input  wire logic            sys_clk_in,
  input  wire logic            rstn_in,
  input  wire logic            clear_in,    // synchronous clear
  input  wire logic            step_in,     // prescaler wrap
  input  wire logic [3:0]      select_in,   // ratio 1:2**select
  output logic [BITS-1:0]      count_out,   // current count
  output logic                 expire_out   // one-cycle expiry pulse
);

  logic [BITS-1:0] cnt_r;   // postscale count
  logic [BITS-1:0] mask_w;  // terminal count for the ratio

  // ---------------------------------------------------------------
  // terminal count
  // ---------------------------------------------------------------
  // 16 ratios from 1:1 up to 1:32768
  assign mask_w     = BITS'((32'h1 << select_in) - 32'h1);
  assign expire_out = step_in & (cnt_r == mask_w) & ~clear_in;
  assign count_out  = cnt_r;

  // ---------------------------------------------------------------
  // counter
  // ---------------------------------------------------------------
  always_ff @(posedge sys_clk_in or negedge rstn_in)
  begin
    if (!rstn_in)
      cnt_r <= '0;
    else if (clear_in || expire_out)
      cnt_r <= '0;
    else if (step_in)
      cnt_r <= cnt_r + 1'b1;
  end

endmodule

`default_nettype wire

// ===== logic/wwdt_top.sv
/*
  windowed watchdog timer top: low-power clock divider, prescaler,
  postscaler, fixed-window clear check, power-state tracking and the
  reset control and configuration registers on a plain register port.
  assumes core events arrive as one-cycle pulses on sys_clk_in and that
  the reset controller feeds wdt_reset_out back as dev_reset.
*/
// Behaviour
// - clock from low-power oscillator, enabled with watchdog
// - prescaler divides by 32 or 128
// - base period 1 ms or 4 ms
// - postscaler field selects 16 ratios
// - clear counters on reset, switch, power-save, clear
// - time-out in sleep/idle wakes device
// - sticky time-out flag, software clears it
// - window mode: early clear resets device
// - window mode when window disable bit zero
// - hardware enable forces watchdog on
// - otherwise software enable bit runs watchdog
// - software enable cleared on device reset
`timescale 1ns/1ps
`default_nettype none

`include "wwdt_regs.svh"

module wwdt_top
#(
  parameter int LOW_POWER_RC_CLOCK_DIV = `WWDT_LOW_POWER_RC_CLOCK_DIV_CYC  // system cycles per low-power tick
)
(
  input  wire logic                     sys_clk_in,
  input  wire logic                     rstn_in,
  input  wire wwdt_pkg::wwdt_core_evt_t core_evt_in,    // core event pulses
  input  wire wwdt_pkg::wwdt_bus_req_t  bus_req_in,     // register port request
  output logic [7:0]                    rdata_out,      // read data, cycle after read
  output logic                          wdt_reset_out,  // one-cycle reset request
  output logic                          wake_out,       // one-cycle wake request
  output logic                          low_power_rc_clock_en_out     // low-power oscillator enable
);

  import wwdt_pkg::*;

  localparam int DIV_W = $clog2(LOW_POWER_RC_CLOCK_DIV + 1);
  localparam int TOT_W = `WWDT_PRE_LONG_BITS + `WWDT_POST_BITS;

  // ---------------------------------------------------------------
  // declarations
  // ---------------------------------------------------------------
  logic [7:0]       cfg_r;          // config_word_one
  logic             sw_en_r;        // sw_enable_bit
  logic             timeout_r;      // timeout_flag
  logic             sleep_bit_r;    // sleep status
  logic             idle_bit_r;     // idle status
  wwdt_pstate_t     pstate_r;       // power state
  logic [DIV_W-1:0] div_r;          // low-power tick divider
  logic             tick_w;         // low-power tick enable
  logic             enabled_w;      // watchdog running
  logic             clear_w;        // counter clear
  logic             win_mode_w;     // fixed window active
  logic             in_window_w;    // count in last quarter
  logic             early_clr_w;    // clear before window
  logic             expire_w;       // full period elapsed
  logic             asleep_w;       // in sleep or idle
  logic             pre_wrap_w;     // prescaler wrap
  logic [6:0]       pre_cnt_w;      // prescaler count
  logic [14:0]      post_cnt_w;     // postscaler count
  logic             wr_rc_w;        // write to reset control
  logic             wr_cw_w;        // write to config word
  logic [3:0]       ps_sel_w;       // postscale_select_cfg
  logic             pre_long_w;     // prescale_select_cfg
  logic             hw_en_w;        // hw_enable_cfg
  logic             win_dis_w;      // window_disable_cfg

  // ---------------------------------------------------------------
  // window test
  // ---------------------------------------------------------------
  // the last quarter is where the top two bits of the combined count
  // are both set; the combined width is prescale bits plus the postscale select value
  function automatic logic last_quarter(input logic [14:0] post,
                                        input logic [6:0]  pre,
                                        input logic        long_sel,
                                        input logic [3:0]  ps);
    logic [TOT_W-1:0] tot;
    int               n;
    tot = '0;
    n   = 0;
    if (long_sel)
    begin
      tot = {post, pre};
      n   = `WWDT_PRE_LONG_BITS + int'(ps);
    end
    else
    begin
      tot = TOT_W'({post, pre[4:0]});
      n   = `WWDT_PRE_SHORT_BITS + int'(ps);
    end
    last_quarter = tot[n-1] & tot[n-2];
  endfunction

  // ---------------------------------------------------------------
  // field decode
  // ---------------------------------------------------------------
  assign ps_sel_w   = cfg_r[`WWDT_CW_PS_MSB:`WWDT_CW_PS_LSB];
  assign pre_long_w = cfg_r[`WWDT_CW_PRESEL_BIT];
  assign hw_en_w    = cfg_r[`WWDT_CW_HWEN_BIT];
  assign win_dis_w  = cfg_r[`WWDT_CW_WINDOW_DISABLE_CFG_BIT];
  assign wr_rc_w    = bus_req_in.wr && (bus_req_in.addr == `WWDT_OFF_RESET_CTRL);
  assign wr_cw_w    = bus_req_in.wr && (bus_req_in.addr == `WWDT_OFF_CONFIG_ONE);

  // hardware enable cannot be overridden by the software enable bit
  assign enabled_w  = hw_en_w | sw_en_r;
  assign asleep_w   = (pstate_r != WWDT_RUN);
  assign win_mode_w = ~win_dis_w;

  // every counter clear source in one term
  assign clear_w = core_evt_in.dev_reset | core_evt_in.clk_switch_done
                 | core_evt_in.power_save_instruction_enter | core_evt_in.power_save_instruction_exit
                 | (core_evt_in.clear_instr & ~asleep_w)
                 | ~enabled_w;

  assign in_window_w = last_quarter(post_cnt_w, pre_cnt_w, pre_long_w, ps_sel_w);
  // a clear only counts during normal execution
  assign early_clr_w = enabled_w & win_mode_w & core_evt_in.clear_instr
                     & ~asleep_w & ~in_window_w;

  // ---------------------------------------------------------------
  // low-power tick divider
  // ---------------------------------------------------------------
  // stands in for the 31 khz oscillator; it only runs while the watchdog
  // is enabled so the oscillator enable and the ticks agree
  always_ff @(posedge sys_clk_in or negedge rstn_in)
  begin
    if (!rstn_in)
      div_r <= '0;
    else if (!enabled_w || clear_w)
      div_r <= '0;
    else if (div_r == DIV_W'(LOW_POWER_RC_CLOCK_DIV - 1))
      div_r <= '0;
    else
      div_r <= div_r + 1'b1;
  end

  assign tick_w = enabled_w & ~clear_w & (div_r == DIV_W'(LOW_POWER_RC_CLOCK_DIV - 1));

  // ---------------------------------------------------------------
  // prescaler and postscaler
  // ---------------------------------------------------------------
  // 32 ticks give 1 ms and 128 ticks give 4 ms at the nominal rate
  wwdt_prescaler #(
    .LONG_BITS   (`WWDT_PRE_LONG_BITS)
  ) u_pre (
    .sys_clk_in  (sys_clk_in),
    .rstn_in     (rstn_in),
    .clear_in    (clear_w),
    .tick_in     (tick_w),
    .long_sel_in (pre_long_w),
    .count_out   (pre_cnt_w),
    .wrap_out    (pre_wrap_w)
  );

  wwdt_postscaler #(
    .BITS        (`WWDT_POST_BITS)
  ) u_post (
    .sys_clk_in  (sys_clk_in),
    .rstn_in     (rstn_in),
    .clear_in    (clear_w),
    .step_in     (pre_wrap_w),
    .select_in   (ps_sel_w),
    .count_out   (post_cnt_w),
    .expire_out  (expire_w)
  );

  // ---------------------------------------------------------------
  // power state
  // ---------------------------------------------------------------
  // tracks sleep and idle so an expiry there wakes instead of resetting
  always_ff @(posedge sys_clk_in or negedge rstn_in)
  begin
    if (!rstn_in)
      pstate_r <= WWDT_RUN;
    else if (core_evt_in.dev_reset)
      pstate_r <= WWDT_RUN;
    else
    begin
      case (pstate_r)
        WWDT_RUN:
          if (core_evt_in.power_save_instruction_enter)
            pstate_r <= core_evt_in.power_save_instruction_idle ? WWDT_IDLE : WWDT_SLEEP;
        WWDT_SLEEP,
        WWDT_IDLE:
          // leave on the core's exit event or on our own wake
          if (core_evt_in.power_save_instruction_exit || expire_w)
            pstate_r <= WWDT_RUN;
        default:
          pstate_r <= WWDT_RUN;
      endcase
    end
  end

  // ---------------------------------------------------------------
  // reset and wake requests
  // ---------------------------------------------------------------
  // registered so both leave the block straight from a flip-flop
  always_ff @(posedge sys_clk_in or negedge rstn_in)
  begin
    if (!rstn_in)
    begin
      wdt_reset_out <= 1'b0;
      wake_out      <= 1'b0;
    end
    else
    begin
      wdt_reset_out <= (expire_w & ~asleep_w) | early_clr_w;
      wake_out      <= expire_w & asleep_w;
    end
  end

  // oscillator enable follows the watchdog enable
  always_ff @(posedge sys_clk_in or negedge rstn_in)
  begin
    if (!rstn_in)
      low_power_rc_clock_en_out <= 1'b0;
    else
      low_power_rc_clock_en_out <= enabled_w;
  end

  // ---------------------------------------------------------------
  // configuration word
  // ---------------------------------------------------------------
  // writable here so one part can be retargeted; real parts would load
  // it once from nonvolatile storage
  always_ff @(posedge sys_clk_in or negedge rstn_in)
  begin
    if (!rstn_in)
      cfg_r <= `WWDT_CW_RESET;
    else if (wr_cw_w)
      cfg_r <= bus_req_in.wdata;
  end

  // ---------------------------------------------------------------
  // software enable
  // ---------------------------------------------------------------
  always_ff @(posedge sys_clk_in or negedge rstn_in)
  begin
    if (!rstn_in)
      sw_en_r <= 1'b0;
    else if (core_evt_in.dev_reset)
      sw_en_r <= 1'b0;
    else if (wr_rc_w)
      sw_en_r <= bus_req_in.wdata[`WWDT_RC_SWEN_BIT];
  end

  // ---------------------------------------------------------------
  // sticky status bits
  // ---------------------------------------------------------------
  // hardware set beats a software clear in the same cycle; a device
  // reset does not touch them so software can see why it restarted
  always_ff @(posedge sys_clk_in or negedge rstn_in)
  begin
    if (!rstn_in)
      timeout_r <= 1'b0;
    else if (expire_w || early_clr_w)
      timeout_r <= 1'b1;
    else if (wr_rc_w)
      timeout_r <= bus_req_in.wdata[`WWDT_RC_TIMEOUT_BIT];
  end

  // sleep and idle bits are only ever cleared by software
  always_ff @(posedge sys_clk_in or negedge rstn_in)
  begin
    if (!rstn_in)
    begin
      sleep_bit_r <= 1'b0;
      idle_bit_r  <= 1'b0;
    end
    else
    begin
      if (core_evt_in.power_save_instruction_enter && !asleep_w && !core_evt_in.power_save_instruction_idle)
        sleep_bit_r <= 1'b1;
      else if (wr_rc_w)
        sleep_bit_r <= bus_req_in.wdata[`WWDT_RC_SLEEP_BIT];
      if (core_evt_in.power_save_instruction_enter && !asleep_w && core_evt_in.power_save_instruction_idle)
        idle_bit_r <= 1'b1;
      else if (wr_rc_w)
        idle_bit_r <= bus_req_in.wdata[`WWDT_RC_IDLE_BIT];
    end
  end

  // ---------------------------------------------------------------
  // read port
  // ---------------------------------------------------------------
  // unmapped addresses and non-read cycles return zero
  always_ff @(posedge sys_clk_in or negedge rstn_in)
  begin
    if (!rstn_in)
      rdata_out <= 8'h00;
    else if (bus_req_in.rd && bus_req_in.addr == `WWDT_OFF_RESET_CTRL)
    begin
      rdata_out                       <= 8'h00;
      rdata_out[`WWDT_RC_SWEN_BIT]    <= sw_en_r;
      rdata_out[`WWDT_RC_TIMEOUT_BIT] <= timeout_r;
      rdata_out[`WWDT_RC_SLEEP_BIT]   <= sleep_bit_r;
      rdata_out[`WWDT_RC_IDLE_BIT]    <= idle_bit_r;
    end
    else if (bus_req_in.rd && bus_req_in.addr == `WWDT_OFF_CONFIG_ONE)
      rdata_out <= cfg_r;
    else
      rdata_out <= 8'h00;
  end

endmodule

`default_nettype wire

// ===== verif/wwdt_checker.sv
/*
  port checker for wwdt_top: pulse widths, enables, read timing, window.
  assumes it is bound to wwdt_top and sees only that module's ports.
*/
`timescale 1ns/1ps
`default_nettype none

module wwdt_checker
#(
  parameter int LOW_POWER_RC_CLOCK_DIV = 4
)
(
  input  wire logic                     sys_clk_in,
  input  wire logic                     rstn_in,
  input  wire wwdt_pkg::wwdt_core_evt_t core_evt_in,
  input  wire wwdt_pkg::wwdt_bus_req_t  bus_req_in,
  input  wire logic [7:0]               rdata_out,
  input  wire logic                     wdt_reset_out,
  input  wire logic                     wake_out,
  input  wire logic                     low_power_rc_clock_en_out
);
  import wwdt_pkg::*;
  // -----------------------------------------------------------
  // helper shadows
  // -----------------------------------------------------------
  localparam int MIN_GAP = LOW_POWER_RC_CLOCK_DIV * 31; // shortest period, tick phase allowed
  localparam int EARLY   = LOW_POWER_RC_CLOCK_DIV * 8;  // far ahead of any window
  logic [7:0] cfg_r;   // config word as written
  logic       swen_r;  // software enable as written
  logic       flag_r;  // a timeout was seen
  logic       sleep_r; // sleeping or idle
  logic       live_r;  // one edge past reset
  int         since_r; // cycles since the counters were cleared
  wire logic  en_w  = cfg_r[7] | swen_r;
  wire logic  wr0_w = bus_req_in.wr && (bus_req_in.addr == 4'h0);
  wire logic  clr_w = core_evt_in.dev_reset | core_evt_in.clk_switch_done |
                      core_evt_in.power_save_instruction_enter | core_evt_in.power_save_instruction_exit |
                      core_evt_in.clear_instr;

  default clocking cb @(posedge sys_clk_in);
  endclocking
  default disable iff (!rstn_in);

  // config shadow, unprogrammed word is all ones
  always_ff @(posedge sys_clk_in or negedge rstn_in)
    if (!rstn_in)
      cfg_r <= 8'hff;
    else if (bus_req_in.wr && (bus_req_in.addr == 4'h1))
      cfg_r <= bus_req_in.wdata;

  // software enable, dropped by any device reset
  always_ff @(posedge sys_clk_in or negedge rstn_in)
    if (!rstn_in)
      swen_r <= 1'b0;
    else if (core_evt_in.dev_reset)
      swen_r <= 1'b0;
    else if (wr0_w)
      swen_r <= bus_req_in.wdata[5];

  // clear wins here: the shadow lags the real flag by one edge
  always_ff @(posedge sys_clk_in or negedge rstn_in)
    if (!rstn_in)
      flag_r <= 1'b0;
    else if (wr0_w && !bus_req_in.wdata[4])
      flag_r <= 1'b0;
    else if (wdt_reset_out | wake_out)
      flag_r <= 1'b1;

  // power state
  always_ff @(posedge sys_clk_in or negedge rstn_in)
    if (!rstn_in)
      sleep_r <= 1'b0;
    else if (core_evt_in.dev_reset | core_evt_in.power_save_instruction_exit | wake_out)
      sleep_r <= 1'b0;
    else if (core_evt_in.power_save_instruction_enter)
      sleep_r <= 1'b1;

  // past-reset marker, keeps $stable away from reset values
  always_ff @(posedge sys_clk_in or negedge rstn_in)
    if (!rstn_in)
      live_r <= 1'b0;
    else
      live_r <= 1'b1;

  // cycle count since the last clearing event, saturating
  always_ff @(posedge sys_clk_in or negedge rstn_in)
    if (!rstn_in)
      since_r <= 0;
    else if (clr_w)
      since_r <= 0;
    else if (since_r < 32'h000f_ffff)
      since_r <= since_r + 1;

  // -----------------------------------------------------------
  // assertions
  // -----------------------------------------------------------
  rd_quiet_a: assert property (!$past(bus_req_in.rd) |-> rdata_out == 8'h00)
    else $error("read data outside the read answer cycle");
  cfg_read_a: assert property (bus_req_in.rd && bus_req_in.addr == 4'h1 |=> rdata_out == $past(cfg_r))
    else $error("config read back differs from written value");
  swen_read_a: assert property (wr0_w == 1'b0 && bus_req_in.rd && bus_req_in.addr == 4'h0 |=> rdata_out[5] == $past(swen_r))
    else $error("software enable read back wrong");
  flag_read_a: assert property (bus_req_in.rd && bus_req_in.addr == 4'h0 && flag_r |=> rdata_out[4])
    else $error("timeout flag lost");
  osc_follow_a: assert property (live_r && $stable(en_w) |-> low_power_rc_clock_en_out == en_w)
    else $error("oscillator enable does not follow watchdog enable");
  rst_pulse_a: assert property (wdt_reset_out |=> !wdt_reset_out)
    else $error("reset request longer than one cycle");
  wake_pulse_a: assert property (wake_out |=> !wake_out && !wdt_reset_out)
    else $error("wake request longer than one cycle");
  asleep_wake_a: assert property (wdt_reset_out && !$past(core_evt_in.power_save_instruction_enter) && !$past(core_evt_in.power_save_instruction_enter, 2) |-> !sleep_r)
    else $error("reset request while asleep");
  min_gap_a: assert property (wdt_reset_out && !$past(core_evt_in.clear_instr) && !$past(core_evt_in.clear_instr, 2) |-> since_r >= MIN_GAP)
    else $error("reset request before the shortest period");
  early_clr_a: assert property (core_evt_in.clear_instr && !sleep_r && cfg_r[7] && !cfg_r[6] && since_r < EARLY |-> ##[1:2] wdt_reset_out)
    else $error("early clear in window mode gave no reset");
endmodule

`default_nettype wire

// ===== verif/tb_top.sv
/*
  testbench for wwdt_top: register table, period table, clear events,
  sleep wake, window clears, software enable and a second reset.
  assumes the package, header and design files are compiled first.
*/
`timescale 1ns/1ps
`default_nettype none

module tb_top;
  import wwdt_pkg::*;
  typedef struct { logic [3:0] a; logic [7:0] w; logic [7:0] e; } wwdt_row_t;
  localparam int D = 4;                 // shortened low-power tick
  logic           sys_clk_in = 1'b0;
  logic           rstn_in    = 1'b0;
  wwdt_core_evt_t evt        = '0;      // core event pulses
  wwdt_bus_req_t  req        = '0;      // register port
  logic [7:0]     rdata;
  logic           rst_o;
  logic           wake_o;
  logic           low_power_rc_clock_o;
  logic [1:0]     kind;                 // {reset, wake} seen by watch
  int             errors     = 0;
  int             tests_run  = 0;
  int             n;
  // address, write value, read back
  wwdt_row_t rows [6] = '{'{4'h0, 8'hf3, 8'h30}, '{4'h0, 8'h00, 8'h00},
    '{4'h1, 8'h5a, 8'h5a}, '{4'h1, 8'ha5, 8'ha5}, '{4'h5, 8'hff, 8'h00},
    '{4'h1, 8'hff, 8'hff}};
  logic [7:0] pcfg [4] = '{8'hc0, 8'hd0, 8'hc1, 8'hd2};
  int         pexp [4] = '{32 * D, 128 * D, 64 * D, 512 * D};

  always #2 sys_clk_in = ~sys_clk_in;

  wwdt_top #(.LOW_POWER_RC_CLOCK_DIV(D)) u_dut (
    .sys_clk_in    (sys_clk_in),
    .rstn_in       (rstn_in),
    .core_evt_in   (evt),
    .bus_req_in    (req),
    .rdata_out     (rdata),
    .wdt_reset_out (rst_o),
    .wake_out      (wake_o),
    .low_power_rc_clock_en_out   (low_power_rc_clock_o)
  );

  task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
    tests_run++;
    if (got !== exp)
    begin
      errors++;
      $display("wrong value %s expected %0h seen %0h", nm, exp, got);
    end
  endtask

  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge sys_clk_in);
    req.wr    <= 1'b1;
    req.addr  <= a;
    req.wdata <= d;
    @(posedge sys_clk_in);
    req.wr    <= 1'b0;
  endtask

  task automatic rd(input logic [3:0] a, input logic [7:0] e);
    @(posedge sys_clk_in);
    req.rd   <= 1'b1;
    req.addr <= a;
    @(posedge sys_clk_in);
    req.rd   <= 1'b0;
    #1 chk("read data", e, rdata);
  endtask

  task automatic pulse(input wwdt_core_evt_t e);
    @(posedge sys_clk_in);
    evt <= e;
    @(posedge sys_clk_in);
    evt <= '0;
  endtask

  // wait for a reset or wake request; a reset is fed back as device reset
  task automatic watch(input int lim, output int cnt, output logic [1:0] k);
    cnt = 0;
    #1;
    while (cnt < lim && rst_o !== 1'b1 && wake_o !== 1'b1)
    begin
      @(posedge sys_clk_in);
      #1 cnt++;
    end
    k = {rst_o, wake_o};
    if (rst_o === 1'b1)
      pulse(6'h20);
  endtask

  task automatic give_verdict;
    $display("comparisons %0d mismatches %0d", tests_run, errors);
    if (errors == 0 && tests_run > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask

  initial
  begin
    repeat (8) @(posedge sys_clk_in);
    rstn_in <= 1'b1;
    rd(4'h0, 8'h00);
    rd(4'h1, 8'hff);
    for (int i = 0; i < 6; i++)
    begin
      wr(rows[i].a, rows[i].w);
      rd(rows[i].a, rows[i].e);
    end
    $display("register table done");
    for (int i = 0; i < 4; i++)
    begin
      wr(4'h1, pcfg[i]);
      pulse(6'h10);
      watch(5000, n, kind);
      chk("timeout kind", 2'b10, kind);
      chk("period", 1, n >= pexp[i] - D && n <= pexp[i] + 3);
      rd(4'h0, 8'h10);
      wr(4'h0, 8'h00);
    end
    $display("period table done");
    wr(4'h1, 8'hc0);
    // restart by a clear instruction, then by a power-save exit event
    for (int i = 0; i < 2; i++)
    begin
      pulse(6'h10);
      repeat (100) @(posedge sys_clk_in);
      pulse(i ? 6'h02 : 6'h01);
      watch(5000, n, kind);
      chk("restart", 1, n >= 31 * D && kind == 2'b10);
      rd(4'h0, 8'h10);
      wr(4'h0, 8'h00);
    end
    $display("clear restart done");
    for (int i = 0; i < 2; i++)
    begin
      pulse(i ? 6'h0c : 6'h08);
      rd(4'h0, i ? 8'h04 : 8'h08);
      watch(5000, n, kind);
      chk("wake kind", 2'b01, kind);
      rd(4'h0, i ? 8'h14 : 8'h18);
      wr(4'h0, 8'h00);
    end
    $display("sleep wake done");
    wr(4'h1, 8'h80);
    pulse(6'h10);
    repeat (10) @(posedge sys_clk_in);
    pulse(6'h01);
    watch(3, n, kind);
    chk("early clear", 2'b10, kind);
    rd(4'h0, 8'h10);
    wr(4'h0, 8'h00);
    pulse(6'h10);
    repeat (110) @(posedge sys_clk_in);
    pulse(6'h01);
    watch(5000, n, kind);
    chk("late clear", 1, n >= 31 * D);
    $display("window done");
    wr(4'h1, 8'h40);
    watch(300, n, kind);
    chk("disabled quiet", 2'b00, kind);
    chk("osc off", 1'b0, low_power_rc_clock_o);
    wr(4'h0, 8'h20);
    pulse(6'h10);
    watch(5000, n, kind);
    chk("sw timeout", 2'b10, kind);
    rd(4'h0, 8'h10);
    wr(4'h0, 8'h00);
    $display("software enable done");
    @(posedge sys_clk_in);
    rstn_in <= 1'b0;
    repeat (2) @(posedge sys_clk_in);
    rstn_in <= 1'b1;
    rd(4'h1, 8'hff);
    rd(4'h0, 8'h00);
    $display("second reset done");
    give_verdict();
  end

  // hang guard, about nine times the expected run
  initial
  begin
    #160000;
    errors++;
    give_verdict();
  end
endmodule

bind wwdt_top wwdt_checker #(.LOW_POWER_RC_CLOCK_DIV(LOW_POWER_RC_CLOCK_DIV)) u_chk (
  .sys_clk_in    (sys_clk_in),
  .rstn_in       (rstn_in),
  .core_evt_in   (core_evt_in),
  .bus_req_in    (bus_req_in),
  .rdata_out     (rdata_out),
  .wdt_reset_out (wdt_reset_out),
  .wake_out      (wake_out),
  .low_power_rc_clock_en_out   (low_power_rc_clock_en_out)
);

`default_nettype wire
